//--- design/wiper_regs.svh
// register offsets, field positions, reset values and timing figures of the wiper and washer controller
`ifndef WIPER_REGS_SVH
`define WIPER_REGS_SVH

// ===================================
// register map (byte addresses)
`define WW_CTRL_OFFSET 12'h000
`define WW_STATUS_OFFSET 12'h004

// ===================================
// control register fields
`define WW_CTRL_RWASH_WIPE_BIT 0
`define WW_CTRL_RESET 32'h0000_0000

// ===================================
// status register fields
`define WW_STAT_FRONT_WIPE_BIT 0
`define WW_STAT_REAR_WIPE_BIT 1
`define WW_STAT_FRONT_PUMP_BIT 2
`define WW_STAT_REAR_PUMP_BIT 3
`define WW_STAT_HEAD_WASH_BIT 4
`define WW_STAT_INPUTS_LSB 8

// ===================================
// switch input vector positions
`define WW_IN_IGN1 0
`define WW_IN_IGN2 1
`define WW_IN_INTERVAL 2
`define WW_IN_FRONT_WASH 3
`define WW_IN_REAR_WIPE 4
`define WW_IN_REAR_WASH 5
`define WW_IN_HEADLAMP 6
`define WW_IN_REVERSE 7
`define WW_IN_SEL_LSB 8
`define WW_IN_COUNT 11

// ===================================
// timing, clock rate and tick period
`define WW_CLK_KHZ 20000
`define WW_TICK_MS 1
`define WW_TICK_CYCLES (`WW_CLK_KHZ * `WW_TICK_MS)
`define WW_DEBOUNCE_MS 100
`define WW_DEBOUNCE_TICKS ((`WW_DEBOUNCE_MS + `WW_TICK_MS - 1) / `WW_TICK_MS)
`define WW_PAUSE_MIN_MS 3000
`define WW_PAUSE_STEP_MS 2000
`define WW_PAUSE_STEPS 5
`define WW_RWASH_DELAY_MS 400
`define WW_RWASH_DELAY_TICKS ((`WW_RWASH_DELAY_MS + `WW_TICK_MS - 1) / `WW_TICK_MS)
`define WW_WIPE_CYCLE_MS 1200
`define WW_WIPE_CYCLE_TICKS (`WW_WIPE_CYCLE_MS / `WW_TICK_MS)
`define WW_WASH_CYCLES 3

`endif

//--- design/wiper_pkg.sv
// types shared by the wiper and washer controller
package wiper_pkg;

  // ===================================
  // front wiper sequencer states
  typedef enum logic [1:0] {
    front_idle,
    front_wipe,
    front_pause
  } front_state_t;

  // ===================================
  // millisecond counter type, wide enough for the longest pause
  typedef logic [13:0] ms_count_t;

endpackage : wiper_pkg

//--- design/wiper_tick.sv
// fixed-period tick generator from the system clock
`timescale 1ns/1ns
`default_nettype none
`include "wiper_regs.svh"

module wiper_tick #(
  parameter int TICK_CYCLES = `WW_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // one-cycle tick pulse
  output logic tick
);

  // ===================================
  // cycle counter
  localparam int CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] cnt_q; // cycles since last tick
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;
  wire wrap = (cnt_q == CW'(TICK_CYCLES - 1));

  assign cnt_d = wrap ? '0 : cnt_q + CW'(1);
  assign tick_d = wrap;
  assign tick = tick_q;

  // counter cleared on reset so all timing starts aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule : wiper_tick
`default_nettype wire

//--- design/wiper_debounce.sv
// two-flop synchroniser and tick-based debouncer for switch pins
`timescale 1ns/1ns
`default_nettype none
`include "wiper_regs.svh"

module wiper_debounce #(
  parameter int WIDTH = `WW_IN_COUNT,
  parameter int STABLE_TICKS = `WW_DEBOUNCE_TICKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // tick and raw pins
  input wire logic tick,
  input wire logic [WIDTH-1:0] pins,
  // filtered levels
  output logic [WIDTH-1:0] clean
);

  localparam int DW = $clog2(STABLE_TICKS + 1);

  // ===================================
  // synchroniser, first stage feeds only the second
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] clean_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  assign clean = clean_q;

  // ===================================
  // one stability counter per input
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [DW-1:0] cnt_q; // ticks the new level has held
      logic [DW-1:0] cnt_d;
      wire differs = (sync_q[i] != clean_q[i]);
      wire settled = (cnt_q == DW'(STABLE_TICKS - 1)) && tick;
      // any bounce back restarts the count, so short blips are dropped
      assign cnt_d = !differs ? '0 : (tick ? cnt_q + DW'(1) : cnt_q);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= '0;
          clean_q[i] <= 1'b0;
        end else if (differs && settled) begin
          cnt_q <= '0;
          clean_q[i] <= sync_q[i];
        end else begin
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate

endmodule : wiper_debounce
`default_nettype wire

//--- design/wiper_washer_controller.sv
// wiper and washer controller: switch inputs, relay outputs and apb register access
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wiper_regs.svh"

module wiper_washer_controller #(
  parameter int TICK_CYCLES = `WW_TICK_CYCLES,
  parameter int DEBOUNCE_TICKS = `WW_DEBOUNCE_TICKS,
  parameter int WIPE_CYCLE_TICKS = `WW_WIPE_CYCLE_TICKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // ignition and vehicle status pins
  input wire logic ign_pos1,
  input wire logic ign_pos2,
  input wire logic headlamps_on,
  input wire logic reverse_sel,
  // driver switch pins
  input wire logic front_interval_sw,
  input wire logic [2:0] interval_sel,
  input wire logic front_wash_sw,
  input wire logic rear_wipe_sw,
  input wire logic rear_wash_sw,
  // relay drive outputs
  output logic front_wiper_run,
  output logic rear_wiper_run,
  output logic front_pump_run,
  output logic rear_pump_run,
  output logic headlamp_wash_run
);

  // ===================================
  // pause length for a selector position, top positions clamp to the longest
  function automatic wiper_pkg::ms_count_t pause_ticks(input logic [2:0] pos);
    logic [2:0] step;
    step = (pos >= 3'(`WW_PAUSE_STEPS)) ? 3'(`WW_PAUSE_STEPS - 1) : pos;
    pause_ticks = 14'((`WW_PAUSE_MIN_MS + `WW_PAUSE_STEP_MS * int'(step)) / `WW_TICK_MS);
  endfunction : pause_ticks

  // ===================================
  // tick source
  logic tick; // one pulse per millisecond

  wiper_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // ===================================
  // pin synchronising and debouncing
  logic [`WW_IN_COUNT-1:0] raw_pins; // gathered switch pins
  logic [`WW_IN_COUNT-1:0] sw; // debounced levels

  assign raw_pins = {interval_sel, reverse_sel, headlamps_on, rear_wash_sw, rear_wipe_sw,
                     front_wash_sw, front_interval_sw, ign_pos2, ign_pos1};

  wiper_debounce #(
    .WIDTH(`WW_IN_COUNT),
    .STABLE_TICKS(DEBOUNCE_TICKS)
  ) u_debounce (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .pins(raw_pins),
    .clean(sw)
  );

  // ===================================
  // ignition gating
  wire ign_front_ok = sw[`WW_IN_IGN1] | sw[`WW_IN_IGN2]; // position I or II
  wire ign_rear_ok = sw[`WW_IN_IGN2]; // position II only
  wire [2:0] sel_pos = sw[`WW_IN_SEL_LSB +: 3];

  // ===================================
  // control register and its decoded field
  logic [31:0] ctrl_q; // software configuration
  wire rwash_wipe_en = ctrl_q[`WW_CTRL_RWASH_WIPE_BIT]; // rear wash also wipes

  // ===================================
  // front washer and interval requests
  // front wash gated
  wire front_wash_req = ign_front_ok & sw[`WW_IN_FRONT_WASH];
  wire interval_req = ign_front_ok & sw[`WW_IN_INTERVAL];

  // ===================================
  // front wiper sequencer
  wiper_pkg::front_state_t fstate_q; // sequencer state
  wiper_pkg::front_state_t fstate_d;
  wiper_pkg::ms_count_t ftime_q; // ticks in current state
  wiper_pkg::ms_count_t ftime_d;
  logic [1:0] wash_left_q; // wash wipes still owed
  logic [1:0] wash_left_d;

  wire [13:0] pause_len = pause_ticks(sel_pos);
  wire wipe_done = tick && (ftime_q == 14'(WIPE_CYCLE_TICKS - 1));
  wire pause_done = tick && (ftime_q >= pause_len - 14'd1);
  wire [1:0] left_after = (wash_left_q != 2'd0) ? wash_left_q - 2'd1 : 2'd0;

  // next state of the front sequencer
  always_comb begin
    fstate_d = fstate_q;
    ftime_d = tick ? ftime_q + 14'd1 : ftime_q;
    wash_left_d = wash_left_q;
    case (fstate_q)
      wiper_pkg::front_idle: begin
        ftime_d = '0;
        if (front_wash_req || interval_req) begin
          fstate_d = wiper_pkg::front_wipe;
        end
      end
      wiper_pkg::front_wipe: begin
        if (wipe_done) begin
          ftime_d = '0;
          wash_left_d = left_after;
          // keep wiping while washing or while wash wipes remain
          if (front_wash_req || left_after != 2'd0) begin
            fstate_d = wiper_pkg::front_wipe;
          end else if (interval_req) begin
            fstate_d = wiper_pkg::front_pause;
          end else begin
            fstate_d = wiper_pkg::front_idle;
          end
        end
      end
      wiper_pkg::front_pause: begin
        if (front_wash_req || pause_done) begin
          // a wash press cuts the pause short
          fstate_d = wiper_pkg::front_wipe;
          ftime_d = '0;
        end else if (!interval_req) begin
          fstate_d = wiper_pkg::front_idle;
        end
      end
      default: begin
        fstate_d = wiper_pkg::front_idle;
      end
    endcase
    if (front_wash_req) begin
      wash_left_d = 2'(`WW_WASH_CYCLES);
    end
    if (!ign_front_ok) begin
      fstate_d = wiper_pkg::front_idle;
      ftime_d = '0;
      wash_left_d = 2'd0;
    end
  end

  // front sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fstate_q <= wiper_pkg::front_idle;
      ftime_q <= '0;
      wash_left_q <= 2'd0;
    end else begin
      fstate_q <= fstate_d;
      ftime_q <= ftime_d;
      wash_left_q <= wash_left_d;
    end
  end

  // ===================================
  // rear wash delay timer
  logic [8:0] rwash_time_q; // ticks the rear wash has been held
  logic [8:0] rwash_time_d;
  wire rear_wash_req = ign_rear_ok & sw[`WW_IN_REAR_WASH];
  wire rwash_delay_over = (rwash_time_q == 9'(`WW_RWASH_DELAY_TICKS));

  // counter saturates once the delay has passed, restarts on release
  assign rwash_time_d = !rear_wash_req ? 9'd0 :
                        (tick && !rwash_delay_over) ? rwash_time_q + 9'd1 : rwash_time_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rwash_time_q <= 9'd0;
    end else begin
      rwash_time_q <= rwash_time_d;
    end
  end

  // ===================================
  // relay drive decisions
  logic front_wiper_q;
  logic rear_wiper_q;
  logic front_pump_q;
  logic rear_pump_q;
  logic head_wash_q;

  wire front_wiper_d = (fstate_q == wiper_pkg::front_wipe);
  wire rwash_wipe = rwash_wipe_en & rear_wash_req & rwash_delay_over;
  wire rear_wiper_d = ign_rear_ok & (sw[`WW_IN_REAR_WIPE] | sw[`WW_IN_REVERSE] | rwash_wipe);
  wire head_wash_d = sw[`WW_IN_HEADLAMP] & front_wash_req;

  // every relay output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_wiper_q <= 1'b0;
      rear_wiper_q <= 1'b0;
      front_pump_q <= 1'b0;
      rear_pump_q <= 1'b0;
      head_wash_q <= 1'b0;
    end else begin
      front_wiper_q <= front_wiper_d;
      rear_wiper_q <= rear_wiper_d;
      front_pump_q <= front_wash_req;
      rear_pump_q <= rear_wash_req;
      head_wash_q <= head_wash_d;
    end
  end

  assign front_wiper_run = front_wiper_q;
  assign rear_wiper_run = rear_wiper_q;
  assign front_pump_run = front_pump_q;
  assign rear_pump_run = rear_pump_q;
  assign headlamp_wash_run = head_wash_q;

  // ===================================
  // apb decode
  logic pready_q; // one wait state, then ready
  logic pslverr_q;
  logic [31:0] prdata_q;

  wire access = psel & penable;
  wire hit_ctrl = (paddr == `WW_CTRL_OFFSET);
  wire hit_status = (paddr == `WW_STATUS_OFFSET);
  wire mapped = hit_ctrl | hit_status;
  wire do_write = access & pready_q & pwrite & hit_ctrl;

  // status word: live outputs plus filtered inputs
  wire [31:0] status_word = {13'd0, sw, 3'd0, head_wash_q, rear_pump_q, front_pump_q,
                             rear_wiper_q, front_wiper_q};
  wire [31:0] read_word = hit_ctrl ? ctrl_q : (hit_status ? status_word : 32'h0000_0000);

  // answer prepared in the first access cycle, presented in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      prdata_q <= (access & ~pready_q & ~pwrite) ? read_word : 32'h0000_0000;
    end
  end

  // control register, only the mode bit is writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `WW_CTRL_RESET;
    end else if (do_write) begin
      ctrl_q <= {31'd0, pwdata[`WW_CTRL_RWASH_WIPE_BIT]};
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule : wiper_washer_controller
`default_nettype wire

//--- test/wiper_washer_controller_chk.sv
// port assertions for the wiper and washer controller
`timescale 1ns/1ns
`default_nettype none
module wiper_washer_controller_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int DEBOUNCE_TICKS = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and relays
  input wire logic ign_pos1,
  input wire logic ign_pos2,
  input wire logic headlamps_on,
  input wire logic front_wash_sw,
  input wire logic rear_wash_sw,
  input wire logic front_wiper_run,
  input wire logic rear_wiper_run,
  input wire logic front_pump_run,
  input wire logic rear_pump_run,
  input wire logic headlamp_wash_run
);
  // ===================================
  // run lengths of raw levels
  // pins pass sync and debounce, so gating is judged after a settle span
  localparam int settle = (DEBOUNCE_TICKS + 2) * TICK_CYCLES + 8;
  wire logic [5:0] lvl = {front_wash_sw, !rear_wash_sw, !front_wash_sw, !headlamps_on, !ign_pos2,
                          !(ign_pos1 | ign_pos2)};
  int run_q [6]; // cycles each level held
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 6; i++) begin
      if (!presetn) run_q[i] <= 0;
      else run_q[i] <= lvl[i] ? run_q[i] + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_front_ign: assert property (run_q[0] > settle |-> !front_wiper_run && !front_pump_run)
    else $error("front relay on without ignition");
  a_rear_ign: assert property (run_q[1] > settle |-> !rear_wiper_run && !rear_pump_run)
    else $error("rear relay on without ignition two");
  a_head_gate: assert property (run_q[2] > settle || run_q[3] > settle |-> !headlamp_wash_run)
    else $error("headlamp wash without lamps and wash");
  a_wash_wipe: assert property ($rose(front_pump_run) |-> ##[0:1] front_wiper_run)
    else $error("front pump without wiper");
  a_pump_filter: assert property ($rose(front_pump_run) |-> run_q[5] > TICK_CYCLES)
    else $error("front pump on a short press");
  a_rear_delay: assert property ($rose(rear_pump_run) && !rear_wiper_run |=> (!rear_wiper_run) [*8])
    else $error("rear wiper too soon after wash");
  a_ready_time: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("error flag wrong for address");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  c_head: cover property ($rose(headlamp_wash_run));
  c_rear: cover property ($rose(rear_wiper_run) && rear_pump_run);
  c_err: cover property (pready && pslverr);
endmodule : wiper_washer_controller_chk
bind wiper_washer_controller wiper_washer_controller_chk #(.TICK_CYCLES(TICK_CYCLES), .DEBOUNCE_TICKS(DEBOUNCE_TICKS))
  chk_inst (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .ign_pos1, .ign_pos2,
  .headlamps_on, .front_wash_sw, .rear_wash_sw, .front_wiper_run, .rear_wiper_run, .front_pump_run,
  .rear_pump_run, .headlamp_wash_run);
`default_nettype wire

//--- test/wiper_switch_panel.sv
// switch panel model: drives the pins, with contact bounce on request
`timescale 1ns/1ns
`default_nettype none
module wiper_switch_panel (
  // clock
  input wire logic pclk,
  // wanted levels and chattering contacts
  input wire logic [10:0] want,
  input wire logic [10:0] flip,
  // pins
  output logic [10:0] pins
);
  // ===================================
  // bounce phase, far shorter than any accepted press
  logic bounce_q = 1'b0;
  always @(posedge pclk) begin
    bounce_q <= !bounce_q;
  end
  assign pins = want ^ (flip & {11{bounce_q}});
endmodule : wiper_switch_panel
`default_nettype wire

//--- test/wiper_washer_controller_tb_top.sv
// self-checking bench for the wiper and washer controller
`timescale 1ns/1ns
`default_nettype none
`include "wiper_regs.svh"
module wiper_washer_controller_tb_top;
  // ===================================
  // scaled timing: one tick is 4 cycles
  localparam int tk = 4;
  localparam int fw = 0, rw = 1, fp = 2, rp = 3, hw = 4; // relay slots
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, r, d;
  logic [10:0] want, flip;
  wire logic [10:0] pins;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  wire logic [4:0] outs;
  int num_errors = 0, compares = 0, n, ctrl_m, seed = 32'h01903863;
  int sels[$] = '{0, 1, 7};
  int rear_pins[2] = '{`WW_IN_REAR_WIPE, `WW_IN_REVERSE};
  always #25 pclk = ~pclk;
  wiper_switch_panel wiper_switch_panel_inst (.pclk(pclk), .want(want), .flip(flip), .pins(pins));
  wiper_washer_controller #(.TICK_CYCLES(tk), .DEBOUNCE_TICKS(2), .WIPE_CYCLE_TICKS(3)) wiper_washer_controller_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ign_pos1(pins[`WW_IN_IGN1]), .ign_pos2(pins[`WW_IN_IGN2]), .headlamps_on(pins[`WW_IN_HEADLAMP]),
    .reverse_sel(pins[`WW_IN_REVERSE]), .front_interval_sw(pins[`WW_IN_INTERVAL]), .interval_sel(pins[10:8]),
    .front_wash_sw(pins[`WW_IN_FRONT_WASH]), .rear_wipe_sw(pins[`WW_IN_REAR_WIPE]),
    .rear_wash_sw(pins[`WW_IN_REAR_WASH]), .front_wiper_run(outs[0]), .rear_wiper_run(outs[1]),
    .front_pump_run(outs[2]), .rear_pump_run(outs[3]), .headlamp_wash_run(outs[4]));
  // ===================================
  // compares, bus cycle, waits
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  // one transfer; entered just after an edge, leaves one idle edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_out(input int s, input logic v, input int lim);
    n = 0;
    while (outs[s] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_out
  // model: pause in cycles, positions above 4 clamp
  function automatic int exp_pause(input int s);
    return (3000 + 2000 * (s > 4 ? 4 : s)) * tk;
  endfunction : exp_pause
  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, num_errors);
  endtask : done
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // watchdog sized from the longest pauses
  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    summarize();
  end
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    want <= 11'h000;
    flip <= 11'h000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    check_word(r, 32'h0);
    repeat (4) begin
      d = $random(seed);
      ctrl_m = d[0];
      apb(1'b1, 12'h000, d);
      apb(1'b0, 12'h000, 32'h0);
      check_word(r, 32'(ctrl_m));
    end
    apb(1'b1, 12'h004, 32'hffff_ffff);
    check_bit(e, 1'b0);
    apb(1'b1, 12'h008, ~d);
    check_bit(e, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    check_word({r[31:1], r[0] | ~e}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check_word(r, 32'(ctrl_m));
    done("registers");
    // wash, rear wipe, headlamp and reverse switches on, interval off, ignition off, then position I only
    want <= 11'h0f8;
    repeat (60) @(posedge pclk);
    check_word(32'(outs), 32'h0);
    want[`WW_IN_IGN1] <= 1'b1;
    repeat (40) @(posedge pclk);
    check_word(32'(outs), 32'h15);
    apb(1'b0, 12'h004, 32'h0);
    check_word(r, 32'h0000_f915);
    want[`WW_IN_HEADLAMP] <= 1'b0;
    repeat (40) @(posedge pclk);
    check_bit(outs[hw], 1'b0);
    want <= 11'h001;
    wait_out(fw, 0, 100);
    check_bit(outs[fw], 1'b0);
    done("gating");
    flip[`WW_IN_FRONT_WASH] <= 1'b1;
    wait_out(fp, 1, 80);
    check_bit(n == 80, 1'b1);
    flip <= 11'h000;
    want[`WW_IN_FRONT_WASH] <= 1'b1;
    wait_out(fp, 1, 60);
    repeat (2) @(posedge pclk);
    check_bit(outs[fw], 1'b1);
    repeat (40) @(posedge pclk);
    want[`WW_IN_FRONT_WASH] <= 1'b0;
    wait_out(fp, 0, 60);
    wait_out(fw, 0, 80);
    check_bit(n >= 22 && n <= 44, 1'b1);
    done("wash");
    foreach (sels[j]) begin
      want[`WW_IN_INTERVAL] <= 1'b0;
      want[10:8] <= sels[j][2:0];
      wait_out(fw, 0, 60);
      repeat (40) @(posedge pclk);
      want[`WW_IN_INTERVAL] <= 1'b1;
      wait_out(fw, 1, 60);
      wait_out(fw, 0, 60);
      wait_out(fw, 1, 50000);
      check_bit(n >= exp_pause(sels[j]) - 8 && n <= exp_pause(sels[j]) + 8, 1'b1);
    end
    want <= 11'h003;
    wait_out(fw, 0, 60);
    repeat (40) @(posedge pclk);
    done("interval");
    foreach (rear_pins[b]) begin
      want[rear_pins[b]] <= 1'b1;
      wait_out(rw, 1, 60);
      check_bit(n < 60, 1'b1);
      want[rear_pins[b]] <= 1'b0;
      wait_out(rw, 0, 60);
      check_bit(outs[rw], 1'b0);
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 12'h000, 32'(m));
      want[`WW_IN_REAR_WASH] <= 1'b1;
      wait_out(rp, 1, 60);
      check_bit(n < 60, 1'b1);
      wait_out(rw, 1, 1700);
      check_bit(m ? (n >= 400 * tk - 12 && n <= 400 * tk + 12) : n == 1700, 1'b1);
      want[`WW_IN_REAR_WASH] <= 1'b0;
      wait_out(rw, 0, 60);
      // release must pass the filter, else the next press is a blip and the delay never restarts
      wait_out(rp, 0, 60);
      check_bit(outs[rp], 1'b0);
    end
    done("rear");
    // mid-run reset while washing: relays drop and the mode bit clears
    want[`WW_IN_FRONT_WASH] <= 1'b1;
    wait_out(fp, 1, 60);
    check_bit(outs[fp], 1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check_word(32'(outs), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    check_word(r, 32'h0);
    done("reset");
    summarize();
  end
endmodule : wiper_washer_controller_tb_top
`default_nettype wire
